/* inc/ieeg_pkg.sv */
// Shared constants and carriers of the interrupt edge and enable gating.
package ieeg_pkg;

    // Register bus widths.
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // Register addresses.
    localparam logic [15:0] ADDR_EDGE_SEL = 16'hFFF2;
    localparam logic [15:0] ADDR_EN_ONE = 16'hFFF3;
    localparam logic [15:0] ADDR_EN_TWO = 16'hFFF4;
    localparam logic [15:0] ADDR_EV_STATUS = 16'hFF80;
    localparam logic [15:0] ADDR_EV_MASK = 16'hFF81;

    // Edge select layout: bits 7 to 5 read as one, stored bits in 1 to 0.
    localparam int EDGE_PIN0 = 0;
    localparam int EDGE_PIN1 = 1;
    localparam logic [7:0] EDGE_SEL_FIXED = 8'hE0;
    localparam logic [1:0] EDGE_SEL_RST = 2'h0;

    // First enable register layout.
    localparam int EN1_TIMER_A = 7;
    localparam int EN1_SERIAL = 6;
    localparam int EN1_WAKEUP = 5;
    localparam logic [7:0] EN1_PIN_MASK = 8'h1F;

    // Second enable register layout.
    localparam int EN2_DIRECT = 7;
    localparam int EN2_CONV = 6;
    localparam int EN2_RSVD = 5;
    localparam int EN2_TIMER_G = 4;
    localparam int EN2_TIMER_FH = 3;
    localparam int EN2_TIMER_FL = 2;
    localparam int EN2_TIMER_C = 1;
    localparam int EN2_ASYNC = 0;
    localparam logic [7:0] ENABLE_RST = 8'h00;

    // Event status and mask layout.
    localparam int EV_W = 3;
    localparam int EV_PIN0 = 0;
    localparam int EV_PIN1 = 1;
    localparam int EV_TIMER_C = 2;
    localparam logic [2:0] EV_RST = 3'h0;

    // Idle level of the sensed pins after reset.
    localparam logic LEVEL_RST = 1'h1;

    // One register bus request.
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ieeg_bus_t;

    // Request flags from the sources, or gated requests toward the CPU.
    typedef struct packed {
        logic [7:0] wake;
        logic [7:0] one;
        logic [7:0] two;
    } ieeg_flags_t;

endpackage : ieeg_pkg

/* verilog/ieeg_edge_sense.sv */
`timescale 1ns/100ps
// Synchronises one pin and reports a settled edge of the chosen polarity.
module ieeg_edge_sense (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_i,
    // Pin and polarity.
    input wire logic pin_i,
    input wire logic rising_i,
    // Settled level and one-cycle edge pulse.
    output logic level_o,
    output logic edge_o
);

    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic level_r;
    logic edge_r;
    logic sync1_nxt;
    logic sync2_nxt;
    logic sync3_nxt;
    logic level_nxt;
    logic edge_nxt;

    // A change counts only once the second and third stages agree.
    always_comb begin
        sync1_nxt = pin_i;
        sync2_nxt = sync1_r;
        sync3_nxt = sync2_r;
        level_nxt = level_r;
        edge_nxt = 1'h0;
        if (sync2_r == sync3_r && sync2_r != level_r) begin
            level_nxt = sync2_r;
            edge_nxt = (sync2_r == rising_i);
        end
    end

    // Registers of the synchroniser and the edge pulse.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync1_r <= ieeg_pkg::LEVEL_RST;
            sync2_r <= ieeg_pkg::LEVEL_RST;
            sync3_r <= ieeg_pkg::LEVEL_RST;
            level_r <= ieeg_pkg::LEVEL_RST;
            edge_r <= 1'h0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            sync3_r <= sync3_nxt;
            level_r <= level_nxt;
            edge_r <= edge_nxt;
        end
    end

    assign level_o = level_r;
    assign edge_o = edge_r;

endmodule : ieeg_edge_sense

/* verilog/ieeg_irq_gate.sv */
// How it works
// RULE1: Edge bit 1 picks falling (0, reset) or rising edges on pin 1, timer C.
// RULE2: Edge bit 0 picks falling (0, reset) or rising edges on pin 0.
// RULE3: First enable register is 8-bit read/write, cleared at reset.
// RULE4: First enable bit 7 gates timer A overflow requests.
// RULE5: First enable bit 6 gates serial unit transfer-complete requests.
// RULE6: First enable bit 5 gates all eight wakeup pin requests together.
// RULE7: First enable bits 4 to 0 gate the external pin of same index.
// RULE8: Second enable register is 8-bit read/write, cleared at reset.
// RULE9: Second enable bit 7 gates direct transfer requests.
// RULE10: Second enable bit 6 gates conversion-end requests.
// RULE11: Second enable bit 5 is a plain stored bit, reset to zero.
// RULE12: Second enable bit 4 gates timer G capture and overflow requests.
// RULE13: Second enable bit 3 gates timer F high requests.
// RULE14: Second enable bit 2 gates timer F low requests.
// RULE15: Second enable bit 1 gates timer C overflow and underflow requests.
// RULE16: Second enable bit 0 gates asynchronous counter requests.
// RULE17: A request reaches the CPU only while flag and enable are both set.
`timescale 1ns/100ps
module ieeg_irq_gate (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_i,
    // Register bus.
    input wire ieeg_pkg::ieeg_bus_t bus_i,
    output logic [7:0] rdata_o,
    // Sensed pins.
    input wire logic ext_interrupt_pin_0_i,
    input wire logic ext_interrupt_pin_1_i,
    input wire logic timer_c_event_input_i,
    // Edge pulses toward the request flags.
    output logic pin0_edge_o,
    output logic pin1_edge_o,
    output logic timer_c_edge_o,
    // Request flags in, gated requests out.
    input wire ieeg_pkg::ieeg_flags_t flags_i,
    output ieeg_pkg::ieeg_flags_t req_o,
    // Event interrupt.
    output logic irq_o
);

    // True when the bus writes the given address in this cycle.
    function automatic logic bus_write(input ieeg_pkg::ieeg_bus_t b,
                                       input logic [15:0] a);
        bus_write = b.wr && (b.addr == a);
    endfunction : bus_write

    // True when the bus reads the given address in this cycle.
    function automatic logic bus_read(input ieeg_pkg::ieeg_bus_t b,
                                      input logic [15:0] a);
        bus_read = b.rd && (b.addr == a);
    endfunction : bus_read

    // Widens a three-bit event word to the read data width.
    function automatic logic [7:0] pad_event(input logic [2:0] v);
        pad_event = {5'h00, v};
    endfunction : pad_event

    // Register state and next values.
    logic [1:0] edge_sel_r;
    logic [1:0] edge_sel_nxt;
    logic [7:0] enable_reg_one_r;
    logic [7:0] enable_reg_one_nxt;
    logic [7:0] enable_reg_two_r;
    logic [7:0] enable_reg_two_nxt;
    logic [2:0] ev_mask_r;
    logic [2:0] ev_mask_nxt;
    logic [2:0] ev_status_r;
    logic [2:0] ev_status_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    ieeg_pkg::ieeg_flags_t req_r;
    ieeg_pkg::ieeg_flags_t req_nxt;
    logic irq_r;
    logic irq_nxt;
    logic pin0_edge_r;
    logic pin1_edge_r;
    logic timer_c_edge_r;

    // Raw edge pulses from the sensing cells.
    // Each lasts one cycle and is registered once more before the ports.
    logic pin0_edge;
    logic pin1_edge;
    logic timer_c_edge;
    logic [2:0] ev_hits;

    // Polarity bits, named for the pins they steer.
    logic pin0_edge_polarity;
    logic pin1_edge_polarity;

    // Fixed view of the edge select register as software reads it.
    logic [7:0] pin_edge_select_reg;

    assign pin0_edge_polarity = edge_sel_r[ieeg_pkg::EDGE_PIN0];
    assign pin1_edge_polarity = edge_sel_r[ieeg_pkg::EDGE_PIN1];
    assign pin_edge_select_reg = ieeg_pkg::EDGE_SEL_FIXED
                               | {6'h00, edge_sel_r};

    // Each pin passes three flip-flops, so a pulse shorter than two cycles
    // may be lost, and edges must lie at least two cycles apart.
    // Pin 0 follows edge select bit 0.
    // RULE2: pin zero polarity
    ieeg_edge_sense u_pin0 (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .pin_i(ext_interrupt_pin_0_i),
        .rising_i(pin0_edge_polarity),
        .level_o(),
        .edge_o(pin0_edge)
    );

    // Pin 1 follows edge select bit 1.
    // RULE1: pin one polarity
    ieeg_edge_sense u_pin1 (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .pin_i(ext_interrupt_pin_1_i),
        .rising_i(pin1_edge_polarity),
        .level_o(),
        .edge_o(pin1_edge)
    );

    // The timer C event input shares the polarity of pin 1.
    // RULE1: shared timer polarity
    ieeg_edge_sense u_timer_c (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .pin_i(timer_c_event_input_i),
        .rising_i(pin1_edge_polarity),
        .level_o(),
        .edge_o(timer_c_edge)
    );

    // Collect the edge pulses in the event status layout.
    always_comb begin
        ev_hits = ieeg_pkg::EV_RST;
        ev_hits[ieeg_pkg::EV_PIN0] = pin0_edge;
        ev_hits[ieeg_pkg::EV_PIN1] = pin1_edge;
        ev_hits[ieeg_pkg::EV_TIMER_C] = timer_c_edge;
    end

    // Software writes of the edge select register; bits 7 to 5 are fixed.
    // Bits 4 to 2 are not stored here and always read as zero.
    always_comb begin
        edge_sel_nxt = edge_sel_r;
        if (bus_write(bus_i, ieeg_pkg::ADDR_EDGE_SEL)) begin
            edge_sel_nxt = bus_i.wdata[1:0];
        end
    end

    // Software writes of the first enable register.
    // Every bit is taken as written, since none of them is reserved.
    always_comb begin
        enable_reg_one_nxt = enable_reg_one_r;
        // RULE3: full width write
        if (bus_write(bus_i, ieeg_pkg::ADDR_EN_ONE)) begin
            enable_reg_one_nxt = bus_i.wdata;
        end
    end

    // Software writes of the second enable register, reserved bit kept.
    always_comb begin
        enable_reg_two_nxt = enable_reg_two_r;
        // RULE8: full width write
        // RULE11: reserved bit stored
        if (bus_write(bus_i, ieeg_pkg::ADDR_EN_TWO)) begin
            enable_reg_two_nxt = bus_i.wdata;
        end
    end

    // Software writes of the event mask.
    always_comb begin
        ev_mask_nxt = ev_mask_r;
        if (bus_write(bus_i, ieeg_pkg::ADDR_EV_MASK)) begin
            ev_mask_nxt = bus_i.wdata[2:0];
        end
    end

    // Registers that software writes, all cleared by reset.
    // All sources therefore start masked until software enables them.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            edge_sel_r <= ieeg_pkg::EDGE_SEL_RST;
            // RULE3: cleared at reset
            enable_reg_one_r <= ieeg_pkg::ENABLE_RST;
            // RULE8: cleared at reset
            enable_reg_two_r <= ieeg_pkg::ENABLE_RST;
            ev_mask_r <= ieeg_pkg::EV_RST;
        end else begin
            edge_sel_r <= edge_sel_nxt;
            enable_reg_one_r <= enable_reg_one_nxt;
            enable_reg_two_r <= enable_reg_two_nxt;
            ev_mask_r <= ev_mask_nxt;
        end
    end

    // Sticky event bits; a read clears them, but a new edge wins.
    // Letting the edge win keeps an event that lands on the read strobe.
    always_comb begin
        ev_status_nxt = ev_status_r;
        if (bus_read(bus_i, ieeg_pkg::ADDR_EV_STATUS)) begin
            ev_status_nxt = ieeg_pkg::EV_RST;
        end
        ev_status_nxt = ev_status_nxt | ev_hits;
    end

    // Event status register.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ev_status_r <= ieeg_pkg::EV_RST;
        end else begin
            ev_status_r <= ev_status_nxt;
        end
    end

    // Read data stand for one cycle after the strobe, zero otherwise.
    // Software never waits, since every register answers in the next cycle.
    always_comb begin
        rdata_nxt = 8'h00;
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                ieeg_pkg::ADDR_EDGE_SEL: begin
                    rdata_nxt = pin_edge_select_reg;
                end
                // RULE3: readable by software
                ieeg_pkg::ADDR_EN_ONE: begin
                    rdata_nxt = enable_reg_one_r;
                end
                // RULE8: readable by software
                ieeg_pkg::ADDR_EN_TWO: begin
                    rdata_nxt = enable_reg_two_r;
                end
                ieeg_pkg::ADDR_EV_STATUS: begin
                    rdata_nxt = pad_event(ev_status_r);
                end
                ieeg_pkg::ADDR_EV_MASK: begin
                    rdata_nxt = pad_event(ev_mask_r);
                end
                default: begin
                    rdata_nxt = 8'h00; // Unmapped addresses read as zero.
                end
            endcase
        end
    end

    // Read data register.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Gate each request flag with its enable; flags are never altered.
    // Masking here loses no request, so setting an enable again presents
    // a flag that is still pending one cycle after the enable is stored.
    always_comb begin
        req_nxt = '0;
        // RULE17: flag and enable
        // RULE4: timer A gate
        req_nxt.one[ieeg_pkg::EN1_TIMER_A] =
            flags_i.one[ieeg_pkg::EN1_TIMER_A]
            & enable_reg_one_r[ieeg_pkg::EN1_TIMER_A];
        // RULE5: serial unit gate
        req_nxt.one[ieeg_pkg::EN1_SERIAL] =
            flags_i.one[ieeg_pkg::EN1_SERIAL]
            & enable_reg_one_r[ieeg_pkg::EN1_SERIAL];
        // RULE6: wakeup group gate
        req_nxt.one[ieeg_pkg::EN1_WAKEUP] =
            (|flags_i.wake) & enable_reg_one_r[ieeg_pkg::EN1_WAKEUP];
        req_nxt.wake = flags_i.wake
                     & {8{enable_reg_one_r[ieeg_pkg::EN1_WAKEUP]}};
        // RULE7: per pin gate
        req_nxt.one = req_nxt.one
                    | (flags_i.one & enable_reg_one_r
                       & ieeg_pkg::EN1_PIN_MASK);
        // RULE9: direct transfer gate
        req_nxt.two[ieeg_pkg::EN2_DIRECT] =
            flags_i.two[ieeg_pkg::EN2_DIRECT]
            & enable_reg_two_r[ieeg_pkg::EN2_DIRECT];
        // RULE10: conversion end gate
        req_nxt.two[ieeg_pkg::EN2_CONV] =
            flags_i.two[ieeg_pkg::EN2_CONV]
            & enable_reg_two_r[ieeg_pkg::EN2_CONV];
        // RULE11: reserved bit unused
        req_nxt.two[ieeg_pkg::EN2_RSVD] = 1'h0;
        // RULE12: timer G gate
        req_nxt.two[ieeg_pkg::EN2_TIMER_G] =
            flags_i.two[ieeg_pkg::EN2_TIMER_G]
            & enable_reg_two_r[ieeg_pkg::EN2_TIMER_G];
        // RULE13: timer F high
        req_nxt.two[ieeg_pkg::EN2_TIMER_FH] =
            flags_i.two[ieeg_pkg::EN2_TIMER_FH]
            & enable_reg_two_r[ieeg_pkg::EN2_TIMER_FH];
        // RULE14: timer F low
        req_nxt.two[ieeg_pkg::EN2_TIMER_FL] =
            flags_i.two[ieeg_pkg::EN2_TIMER_FL]
            & enable_reg_two_r[ieeg_pkg::EN2_TIMER_FL];
        // RULE15: timer C gate
        req_nxt.two[ieeg_pkg::EN2_TIMER_C] =
            flags_i.two[ieeg_pkg::EN2_TIMER_C]
            & enable_reg_two_r[ieeg_pkg::EN2_TIMER_C];
        // RULE16: asynchronous counter gate
        req_nxt.two[ieeg_pkg::EN2_ASYNC] =
            flags_i.two[ieeg_pkg::EN2_ASYNC]
            & enable_reg_two_r[ieeg_pkg::EN2_ASYNC];
    end

    // Interrupt level while any unmasked event bit is set.
    // The mask only hides bits from the interrupt; reads still show them.
    always_comb begin
        irq_nxt = |(ev_status_r & ev_mask_r);
    end

    // Output registers: gated requests, interrupt and edge pulses.
    // Registering every port costs one cycle on each request, but keeps
    // the ports free of glitches from the gating logic.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            req_r <= '0;
            irq_r <= 1'h0;
            pin0_edge_r <= 1'h0;
            pin1_edge_r <= 1'h0;
            timer_c_edge_r <= 1'h0;
        end else begin
            req_r <= req_nxt;
            irq_r <= irq_nxt;
            pin0_edge_r <= pin0_edge;
            pin1_edge_r <= pin1_edge;
            timer_c_edge_r <= timer_c_edge;
        end
    end

    // Ports driven straight from flip-flops.
    assign rdata_o = rdata_r;
    assign req_o = req_r;
    assign irq_o = irq_r;
    assign pin0_edge_o = pin0_edge_r;
    assign pin1_edge_o = pin1_edge_r;
    assign timer_c_edge_o = timer_c_edge_r;

endmodule : ieeg_irq_gate

/* test/ieeg_gate_props.sv */
`timescale 1ns/100ps
// Watches the gate ports against shadow copies of its registers.
module ieeg_gate_props (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_i,
    // Register bus.
    input wire ieeg_pkg::ieeg_bus_t bus_i,
    input wire logic [7:0] rdata_o,
    // Pins and edge pulses.
    input wire logic ext_interrupt_pin_0_i,
    input wire logic ext_interrupt_pin_1_i,
    input wire logic timer_c_event_input_i,
    input wire logic pin0_edge_o,
    input wire logic pin1_edge_o,
    input wire logic timer_c_edge_o,
    // Flags and gated requests.
    input wire ieeg_pkg::ieeg_flags_t flags_i,
    input wire ieeg_pkg::ieeg_flags_t req_o,
    input wire logic irq_o
);
    logic [7:0] en1_r;
    logic [7:0] en1_nxt;
    logic [7:0] en2_r;
    logic [7:0] en2_nxt;
    logic [1:0] edg_r;
    logic [1:0] edg_nxt;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // Shadow copies follow each write and clear at reset.
    always_comb begin
        en1_nxt = en1_r;
        en2_nxt = en2_r;
        edg_nxt = edg_r;
        if (bus_i.wr && bus_i.addr == ieeg_pkg::ADDR_EN_ONE) begin
            en1_nxt = bus_i.wdata;
        end
        if (bus_i.wr && bus_i.addr == ieeg_pkg::ADDR_EN_TWO) begin
            en2_nxt = bus_i.wdata;
        end
        if (bus_i.wr && bus_i.addr == ieeg_pkg::ADDR_EDGE_SEL) begin
            edg_nxt = bus_i.wdata[1:0];
        end
        if (reset_i) begin
            en1_nxt = 8'h00;
            en2_nxt = 8'h00;
            edg_nxt = 2'h0;
        end
    end

    // Shadow copies are only registered here.
    always_ff @(posedge clk_i) begin
        en1_r <= en1_nxt;
        en2_r <= en2_nxt;
        edg_r <= edg_nxt;
    end

    // A read request at one address.
    sequence s_rd(logic [15:0] a);
        bus_i.rd && bus_i.addr == a;
    endsequence
    // A clean pin change into the given level, held four samples.
    sequence s_edge(logic p, logic pol);
        (p != pol) [*5] ##1 ((p == pol) && $changed(p)) ##1 (p == pol) [*3];
    endsequence

    property p_gate_one;
        (req_o.one & 8'hDF) == $past(flags_i.one & en1_r & 8'hDF);
    endproperty
    a_gate_one: assert property (p_gate_one)
        else $error("enable one gating wrong");
    property p_gate_wake;
        req_o.wake == $past(flags_i.wake & {8{en1_r[5]}})
            && req_o.one[5] == $past(|flags_i.wake && en1_r[5]);
    endproperty
    a_gate_wake: assert property (p_gate_wake)
        else $error("wakeup group gating wrong");
    property p_gate_two;
        req_o.two == $past(flags_i.two & en2_r & 8'hDF);
    endproperty
    a_gate_two: assert property (p_gate_two)
        else $error("enable two gating wrong");
    property p_read_one;
        s_rd(ieeg_pkg::ADDR_EN_ONE) |=> rdata_o == $past(en1_r);
    endproperty
    a_read_one: assert property (p_read_one)
        else $error("enable one read wrong");
    property p_read_two;
        s_rd(ieeg_pkg::ADDR_EN_TWO) |=> rdata_o == $past(en2_r);
    endproperty
    a_read_two: assert property (p_read_two)
        else $error("enable two read wrong");
    property p_read_edge;
        s_rd(ieeg_pkg::ADDR_EDGE_SEL) |=>
            rdata_o == (ieeg_pkg::EDGE_SEL_FIXED | {6'h00, $past(edg_r)});
    endproperty
    a_read_edge: assert property (p_read_edge)
        else $error("edge select read wrong");
    // The pulse crosses the sensing cell and the port register: two edges.
    property p_pin0_edge;
        s_edge(ext_interrupt_pin_0_i, edg_r[0]) |=> ##1 pin0_edge_o;
    endproperty
    a_pin0_edge: assert property (p_pin0_edge)
        else $error("pin 0 edge missed");
    property p_pin0_wrong;
        s_edge(ext_interrupt_pin_0_i, !edg_r[0]) |=> ##1 !pin0_edge_o;
    endproperty
    a_pin0_wrong: assert property (p_pin0_wrong)
        else $error("pin 0 wrong polarity seen");
    property p_pin1_edge;
        s_edge(ext_interrupt_pin_1_i, edg_r[1]) |=> ##1 pin1_edge_o;
    endproperty
    a_pin1_edge: assert property (p_pin1_edge)
        else $error("pin 1 edge missed");
    property p_tmc_edge;
        s_edge(timer_c_event_input_i, edg_r[1]) |=> ##1 timer_c_edge_o;
    endproperty
    a_tmc_edge: assert property (p_tmc_edge)
        else $error("timer C input edge missed");
endmodule : ieeg_gate_props

bind ieeg_irq_gate ieeg_gate_props i_props (
    .clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .ext_interrupt_pin_0_i(ext_interrupt_pin_0_i),
    .ext_interrupt_pin_1_i(ext_interrupt_pin_1_i),
    .timer_c_event_input_i(timer_c_event_input_i),
    .pin0_edge_o(pin0_edge_o), .pin1_edge_o(pin1_edge_o),
    .timer_c_edge_o(timer_c_edge_o), .flags_i(flags_i), .req_o(req_o),
    .irq_o(irq_o)
);

/* test/tb_top.sv */
`timescale 1ns/100ps
// Drives the gate through its register bus, request flags and pins.
module tb_top;
    localparam logic [15:0] A_EDGE = ieeg_pkg::ADDR_EDGE_SEL;
    localparam logic [15:0] A_EN1 = ieeg_pkg::ADDR_EN_ONE;
    localparam logic [15:0] A_EN2 = ieeg_pkg::ADDR_EN_TWO;
    localparam logic [15:0] A_STAT = ieeg_pkg::ADDR_EV_STATUS;
    localparam logic [15:0] A_MASK = ieeg_pkg::ADDR_EV_MASK;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    ieeg_pkg::ieeg_bus_t bus_i = '0;
    ieeg_pkg::ieeg_flags_t flags_i = '1;
    ieeg_pkg::ieeg_flags_t req_o;
    logic [2:0] pins_r = 3'h7;
    logic [2:0] edge_w;
    logic [5:0] cnt_r = 6'h00;
    logic [7:0] rdata_o;
    logic [7:0] b;
    logic [7:0] w;
    logic [7:0] t;
    logic irq_o;
    int fail_count = 0;
    int compares = 0;

    // Free-running system clock.
    always #20 clk_i = ~clk_i;

    // Counts edge pulses of each source in two-bit fields.
    always @(posedge clk_i) begin
        cnt_r <= cnt_r + {1'b0, edge_w[2], 1'b0, edge_w[1], 1'b0, edge_w[0]};
    end

    ieeg_irq_gate i_dut (
        .clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .ext_interrupt_pin_0_i(pins_r[0]), .ext_interrupt_pin_1_i(pins_r[1]),
        .timer_c_event_input_i(pins_r[2]), .pin0_edge_o(edge_w[0]),
        .pin1_edge_o(edge_w[1]), .timer_c_edge_o(edge_w[2]),
        .flags_i(flags_i), .req_o(req_o), .irq_o(irq_o)
    );

    // Compares one value and reports a mismatch at once.
    task automatic ck(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : ck

    // One write cycle.
    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_i <= '0;
    endtask : bus_wr

    // One read cycle; the data stand only in the following cycle.
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_i <= '0;
        #1;
        ck(rdata_o, exp);
    endtask : rd_chk

    // Lets registered outputs catch up with the inputs.
    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask : settle

    // Moves all three pins and waits past the synchronisers.
    task automatic move_pins(input logic [2:0] v);
        @(posedge clk_i);
        pins_r <= v;
        repeat (8) @(posedge clk_i);
        #1;
    endtask : move_pins

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    // Cuts a hang short well after the tests should have ended.
    initial begin
        repeat (4000) @(posedge clk_i);
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end

    // Main sequence of tests.
    initial begin
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        rd_chk(A_EDGE, 8'hE0);
        rd_chk(A_EN1, 8'h00);
        rd_chk(A_EN2, 8'h00);
        bus_wr(16'h1234, 8'hFF);
        rd_chk(16'h1234, 8'h00);
        settle();
        ck(req_o, 24'h000000);
        $display("reset values test done");
        // One enable bit at a time, with every flag raised.
        for (int i = 0; i < 8; i++) begin
            b = 8'h01 << i;
            w = (i == 5) ? 8'hFF : 8'h00;
            t = (i == 5) ? 8'h00 : b;
            bus_wr(A_EN1, b);
            bus_wr(A_EN2, b);
            settle();
            ck(req_o.one, b);
            ck(req_o.wake, w);
            ck(req_o.two[7:5], t[7:5]);
            ck(req_o.two[4:0], t[4:0]);
            rd_chk(A_EN1, b);
            rd_chk(A_EN2, b);
        end
        $display("enable walk test done");
        bus_wr(A_EN1, 8'hFF);
        bus_wr(A_EN2, 8'hFF);
        @(posedge clk_i);
        flags_i <= '{wake: 8'h10, one: 8'h85, two: 8'h3C};
        settle();
        ck(req_o, 24'h10A51C);
        @(posedge clk_i);
        flags_i <= '{wake: 8'h00, one: 8'hA5, two: 8'hE3};
        settle();
        ck(req_o, 24'h0085C3);
        bus_wr(A_EN1, 8'h00);
        bus_wr(A_EN2, 8'h00);
        settle();
        ck(req_o, 24'h000000);
        $display("flag pattern test done");
        // Falling then rising pins under each polarity.
        for (int p = 0; p < 2; p++) begin
            bus_wr(A_EDGE, p[0] ? 8'hFF : 8'h00);
            bus_wr(A_MASK, p[0] ? 8'h07 : 8'h00);
            rd_chk(A_EDGE, p[0] ? 8'hE3 : 8'hE0);
            move_pins(3'h0);
            ck(cnt_r, 6'h15);
            move_pins(3'h7);
            ck(cnt_r, p[0] ? 6'h2A : 6'h15);
            ck(irq_o, p[0]);
            rd_chk(A_STAT, 8'h07);
            settle();
            ck(irq_o, 1'b0);
            rd_chk(A_STAT, 8'h00);
        end
        $display("edge polarity test done");
        bus_wr(A_EN1, 8'hFF);
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        rd_chk(A_EN1, 8'h00);
        rd_chk(A_EDGE, 8'hE0);
        $display("second reset test done");
        summarize();
    end
endmodule : tb_top
